// file: shared/scp_pkg.sv
// Shared constants and types for the serial configuration port
package scp_pkg;

   // ------------------------------------------------------------
   // Register addresses and bit positions
   // ------------------------------------------------------------
   localparam logic [11:0] ADDR_CFG_READY = 12'h025;
   localparam logic [11:0] ADDR_SOFT_RESET = 12'h100;
   localparam logic [11:0] ADDR_PDN = 12'h101;
   localparam logic [11:0] ADDR_SYNC_CLR = 12'h102;
   localparam logic [11:0] ADDR_SYNC_STATUS = 12'h140;
   localparam logic [11:0] ADDR_PIN_CFG = 12'h146;
   localparam int READY_BIT = 4;
   localparam int SOFT_RST_BIT = 0;
   localparam int PDN_BIT = 4;
   localparam int SYNC_CLR_BIT = 6;
   localparam int SYNC_DET_BIT = 6;
   localparam int PIN_CFG_W = 5;
   localparam logic [7:0] REG_RESET = 8'h00;

   // Address and implemented-bit mask of each register
   typedef struct packed {
      logic [11:0] addr;
      logic [7:0] mask;
   } reg_ent_t;

   localparam int NREG = 36;
   localparam reg_ent_t REG_MAP [NREG] = '{
      '{ADDR_CFG_READY, 8'h10}, '{ADDR_SOFT_RESET, 8'h01},
      '{ADDR_PDN, 8'h10}, '{ADDR_SYNC_CLR, 8'h40},
      '{12'h104, 8'h03}, '{12'h10A, 8'h07}, '{12'h10B, 8'hFF},
      '{12'h110, 8'hA2}, '{12'h111, 8'hFF}, '{12'h112, 8'hFF},
      '{12'h113, 8'hFE}, '{12'h114, 8'h01}, '{12'h115, 8'h0C},
      '{12'h116, 8'hC7}, '{12'h117, 8'hFF}, '{12'h118, 8'hFF},
      '{12'h119, 8'hFF}, '{12'h11A, 8'hFF}, '{12'h11B, 8'hFF},
      '{12'h11C, 8'hFF}, '{12'h11D, 8'hFF}, '{12'h11E, 8'hFF},
      '{12'h132, 8'h80}, '{ADDR_SYNC_STATUS, 8'h40},
      '{ADDR_PIN_CFG, 8'h1F}, '{12'h14A, 8'h17},
      '{12'h14B, 8'hFF}, '{12'h14C, 8'hFF}, '{12'h14D, 8'h0F},
      '{12'h15B, 8'hFF}, '{12'h15C, 8'hFF}, '{12'h160, 8'h03},
      '{12'h161, 8'hFF}, '{12'h162, 8'hDF}, '{12'h163, 8'hFF},
      '{12'h164, 8'hF9}
   };

   // ------------------------------------------------------------
   // Serial frame layout
   // ------------------------------------------------------------
   localparam int ADDR_BITS = 16;
   localparam int DATA_BITS = 8;
   localparam int FRAME_BITS = 24;
   localparam int RW_BIT = 15;

   // ------------------------------------------------------------
   // Pin function codes
   // ------------------------------------------------------------
   localparam logic [4:0] CFG_DEFAULT = 5'h00;
   localparam logic [4:0] CFG_TSTAMP1 = 5'h01;
   localparam logic [4:0] CFG_VREF1 = 5'h02;
   localparam logic [4:0] CFG_PDN1 = 5'h03;
   localparam logic [4:0] CFG_NCO1 = 5'h04;
   localparam logic [4:0] CFG_OVR1 = 5'h05;
   localparam logic [4:0] CFG_PDN0_A = 5'h0A;
   localparam logic [4:0] CFG_PDN0_B = 5'h0B;
   localparam logic [4:0] CFG_VREF0 = 5'h0C;
   localparam logic [4:0] CFG_NCO0 = 5'h0D;
   localparam logic [4:0] CFG_TSTAMP0 = 5'h0E;
   localparam logic [4:0] CFG_OVR0 = 5'h0F;

   typedef enum logic [2:0] {
      FN_NONE, FN_SYNC, FN_TSTAMP, FN_VREF, FN_NCO, FN_PDN, FN_OVR
   } pin_func_t;

   typedef struct packed {
      pin_func_t fn1;
      pin_func_t fn0;
   } pin_map_t;

   typedef struct packed {
      logic out;
      logic oe_n;
   } gpin_t;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_MHZ = 100;
   localparam int WAKE_TIME_US = 3000;
   localparam int WAKE_CYCLES = WAKE_TIME_US * CLK_MHZ;

endpackage

// file: hw/pin_function_decode.sv
// Decoder from pin function code to the role of each general pin
`timescale 1ns/1ps
`default_nettype none

module pin_function_decode
   import scp_pkg::*;
(
   input wire logic [PIN_CFG_W-1:0] cfg,
   output pin_map_t map
);

   // Code to role of both pins
   always_comb begin
      map.fn0 = FN_SYNC;
      map.fn1 = FN_NONE;
      case (cfg)
         CFG_DEFAULT: begin
            map.fn0 = FN_SYNC;
         end
         CFG_TSTAMP1: map.fn1 = FN_TSTAMP;
         CFG_VREF1: map.fn1 = FN_VREF;
         CFG_PDN1: map.fn1 = FN_PDN;
         CFG_NCO1: map.fn1 = FN_NCO;
         CFG_OVR1: map.fn1 = FN_OVR;
         CFG_PDN0_A: map.fn0 = FN_PDN;
         CFG_PDN0_B: begin
            map.fn0 = FN_PDN;
            map.fn1 = FN_OVR;
         end
         CFG_VREF0: map.fn0 = FN_VREF;
         CFG_NCO0: map.fn0 = FN_NCO;
         CFG_TSTAMP0: map.fn0 = FN_TSTAMP;
         CFG_OVR0: begin
            map.fn0 = FN_OVR;
            map.fn1 = FN_SYNC;
         end
         default: begin
            map.fn0 = FN_SYNC;
            map.fn1 = FN_NONE;
         end
      endcase
   end

endmodule

`default_nettype wire

// file: hw/serial_config_port_regs.sv
// Serial configuration port, register bank and general pin control
//
// What this block does
// - Code 00011 pin one, 01010/01011 pin zero powerdown
// - Powerdown acts only with sampling clock running
// - Reset: pin zero sync input, pin one idle
// - Pin roles come from register 0x146
// - Works in defaults without any serial access
// - Pins may drive powerdown and reference select
// - One shared five-bit code sets the roles of both pins together
// - Low twelve address bits pick the register
// - Write byte sampled on shift clock rising edges
// - Read flag set blocks register writes
// - Read byte driven out on falling edges
// - Twelve-bit addresses, byte registers, unused bits zero
// - Powerdown by write or pin, long wake
`timescale 1ns/1ps
`default_nettype none

module serial_config_port_regs
   import scp_pkg::*;
#(
   parameter int WAKE_CYCLES_P = WAKE_CYCLES
)
(
   input wire logic clock,
   input wire logic rst,
   input wire logic serial_frame_select_n,
   input wire logic serial_clock,
   input wire logic serial_data_line_in,
   output logic serial_data_line_out,
   output logic serial_data_line_oe_n,
   input wire logic general_pin_zero_in,
   output gpin_t general_pin_zero_drv,
   input wire logic general_pin_one_in,
   output gpin_t general_pin_one_drv,
   input wire logic sampling_clock_running,
   input wire logic overrange_flag,
   output logic global_powerdown,
   output logic wake_busy,
   output logic sync_reference_pulse,
   output logic timestamp_pulse,
   output logic ext_vref_select,
   output logic nco_switch,
   output logic config_ready
);

   // Refuse a wake time the timer cannot count
   if (WAKE_CYCLES_P < 1) begin
      $error("WAKE_CYCLES_P must be at least one");
   end

   localparam int WW = $clog2(WAKE_CYCLES_P + 1);

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------

   // Table index of an address, minus one when unmapped
   function automatic int find_idx(input logic [11:0] a);
      find_idx = -1;
      for (int i = 0; i < NREG; i++) begin
         if (REG_MAP[i].addr == a) begin
            find_idx = i;
         end
      end
   endfunction

   // Registers whose content the hardware owns
   function automatic logic is_special(input logic [11:0] a);
      is_special = (a == ADDR_CFG_READY) || (a == ADDR_SOFT_RESET)
         || (a == ADDR_SYNC_CLR) || (a == ADDR_SYNC_STATUS);
   endfunction

   // Level of whichever pin carries a given role
   function automatic logic pin_level(input pin_map_t m,
                                      input logic [1:0] g,
                                      input pin_func_t f);
      pin_level = ((m.fn0 == f) && g[0]) || ((m.fn1 == f) && g[1]);
   endfunction

   localparam int PIN_IDX = find_idx(ADDR_PIN_CFG);
   localparam int PDN_IDX = find_idx(ADDR_PDN);

   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   logic [5:0] sync1_q;
   logic [5:0] sync2_q;
   logic sclk_prev_q;
   logic [1:0] gp_prev_q;

   // Two flops on every pin from outside this clock
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sync1_q <= 6'h01;
         sync2_q <= 6'h01;
      end else begin
         sync1_q <= {sampling_clock_running, general_pin_one_in,
                     general_pin_zero_in, serial_data_line_in,
                     serial_clock, serial_frame_select_n};
         sync2_q <= sync1_q;
      end
   end

   logic sen_n;
   logic sclk_s;
   logic sdi_s;
   logic [1:0] gp_s;
   logic clk_run_s;

   assign sen_n = sync2_q[0];
   assign sclk_s = sync2_q[1];
   assign sdi_s = sync2_q[2];
   assign gp_s = sync2_q[4:3];
   assign clk_run_s = sync2_q[5];

   // Previous levels for edge detection
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sclk_prev_q <= 1'b0;
         gp_prev_q <= 2'h0;
      end else begin
         sclk_prev_q <= sclk_s;
         gp_prev_q <= gp_s;
      end
   end

   logic sclk_rise;
   logic sclk_fall;

   // Shift clock edges count only inside a frame
   assign sclk_rise = !sen_n && sclk_s && !sclk_prev_q;
   assign sclk_fall = !sen_n && !sclk_s && sclk_prev_q;

   // ------------------------------------------------------------
   // Serial frame receiver
   // ------------------------------------------------------------
   logic [4:0] bit_cnt_q;
   logic [22:0] shift_q;
   logic [15:0] addr_q;
   logic rd_flag_q;
   logic addr_done;
   logic [15:0] addr_word;
   logic [7:0] wdata;

   // Address word completes on the sixteenth rising edge
   assign addr_done = sclk_rise && (bit_cnt_q == 5'(ADDR_BITS - 1));
   assign addr_word = {shift_q[14:0], sdi_s};
   assign wdata = {shift_q[6:0], sdi_s};

   // Bit counter and shift register
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         bit_cnt_q <= 5'h00;
         shift_q <= 23'h000000;
      end else if (sen_n) begin
         bit_cnt_q <= 5'h00;
      end else if (sclk_rise) begin
         shift_q <= {shift_q[21:0], sdi_s};
         if (bit_cnt_q != 5'(FRAME_BITS)) begin
            bit_cnt_q <= bit_cnt_q + 5'h01;
         end
      end
   end

   // Address word and read flag, held to frame end
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         addr_q <= 16'h0000;
         rd_flag_q <= 1'b0;
      end else if (sen_n) begin
         rd_flag_q <= 1'b0;
      end else if (addr_done) begin
         addr_q <= addr_word;
         rd_flag_q <= addr_word[RW_BIT];
      end
   end

   logic wr_fire;
   logic [11:0] wr_addr;
   int wr_idx;

   // Write on the last data bit of a valid write frame
   assign wr_addr = addr_q[11:0];
   assign wr_idx = find_idx(wr_addr);
   assign wr_fire = sclk_rise && !rd_flag_q
      && (bit_cnt_q == 5'(FRAME_BITS - 1))
      && (addr_q[14:12] == 3'h0);

   // ------------------------------------------------------------
   // Register bank
   // ------------------------------------------------------------
   logic [7:0] regs_q [NREG];
   logic soft_rst_q;
   logic sync_clr;

   // Self-clearing soft reset request
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         soft_rst_q <= 1'b0;
      end else begin
         soft_rst_q <= wr_fire && (wr_addr == ADDR_SOFT_RESET)
            && wdata[SOFT_RST_BIT];
      end
   end

   // Stored registers; defaults hold until written
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < NREG; i++) begin
            regs_q[i] <= REG_RESET;
         end
      end else if (soft_rst_q) begin
         for (int i = 0; i < NREG; i++) begin
            regs_q[i] <= REG_RESET;
         end
      end else if (wr_fire && (wr_idx >= 0)
                   && !is_special(wr_addr)) begin
         regs_q[wr_idx] <= wdata & REG_MAP[wr_idx].mask;
      end
   end

   // Ready once out of any reset
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         config_ready <= 1'b0;
      end else begin
         config_ready <= !soft_rst_q;
      end
   end

   // ------------------------------------------------------------
   // General pin roles
   // ------------------------------------------------------------
   pin_map_t pin_map;
   logic [PIN_CFG_W-1:0] pin_cfg;

   assign pin_cfg = regs_q[PIN_IDX][PIN_CFG_W-1:0];

   pin_function_decode u_decode (
      .cfg(pin_cfg),
      .map(pin_map)
   );

   logic [1:0] gp_rise;
   logic sync_det_q;

   assign gp_rise = gp_s & ~gp_prev_q;
   assign sync_clr = wr_fire && (wr_addr == ADDR_SYNC_CLR)
      && wdata[SYNC_CLR_BIT];

   // Sticky sync detect; a new edge beats the clear
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sync_det_q <= 1'b0;
      end else if (pin_level(pin_map, gp_rise, FN_SYNC)) begin
         sync_det_q <= 1'b1;
      end else if (sync_clr || soft_rst_q) begin
         sync_det_q <= 1'b0;
      end
   end

   // Input roles of the pins
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sync_reference_pulse <= 1'b0;
         timestamp_pulse <= 1'b0;
         ext_vref_select <= 1'b0;
         nco_switch <= 1'b0;
      end else begin
         sync_reference_pulse <= pin_level(pin_map, gp_rise,
                                           FN_SYNC);
         timestamp_pulse <= pin_level(pin_map, gp_rise, FN_TSTAMP);
         ext_vref_select <= pin_level(pin_map, gp_s, FN_VREF);
         nco_switch <= pin_level(pin_map, gp_s, FN_NCO);
      end
   end

   // Overrange output role drives the pin
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         general_pin_zero_drv <= '{out: 1'b0, oe_n: 1'b1};
         general_pin_one_drv <= '{out: 1'b0, oe_n: 1'b1};
      end else begin
         general_pin_zero_drv.out <= overrange_flag;
         general_pin_zero_drv.oe_n <= pin_map.fn0 != FN_OVR;
         general_pin_one_drv.out <= overrange_flag;
         general_pin_one_drv.oe_n <= pin_map.fn1 != FN_OVR;
      end
   end

   // ------------------------------------------------------------
   // Global powerdown and wake timer
   // ------------------------------------------------------------
   logic pdn_req;
   logic [WW-1:0] wake_cnt_q;

   assign pdn_req = regs_q[PDN_IDX][PDN_BIT]
      || pin_level(pin_map, gp_s, FN_PDN);

   // Request follows only while sampling clock runs
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         global_powerdown <= 1'b0;
      end else if (clk_run_s) begin
         global_powerdown <= pdn_req;
      end
   end

   // Wake timer after powerdown ends
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         wake_cnt_q <= '0;
      end else if (global_powerdown) begin
         wake_cnt_q <= WW'(WAKE_CYCLES_P);
      end else if (wake_cnt_q != '0) begin
         wake_cnt_q <= wake_cnt_q - WW'(1);
      end
   end

   assign wake_busy = global_powerdown || (wake_cnt_q != '0);

   // ------------------------------------------------------------
   // Read-back transmitter
   // ------------------------------------------------------------
   logic [7:0] rd_value;
   logic [7:0] tx_q;
   logic [3:0] tx_left_q;
   int rd_idx;

   assign rd_idx = find_idx(addr_word[11:0]);

   // Selected register, unused bits zero
   always_comb begin
      rd_value = 8'h00;
      if (addr_word[11:0] == ADDR_CFG_READY) begin
         rd_value[READY_BIT] = config_ready;
      end else if (addr_word[11:0] == ADDR_SYNC_STATUS) begin
         rd_value[SYNC_DET_BIT] = sync_det_q;
      end else if (rd_idx >= 0) begin
         rd_value = regs_q[rd_idx] & REG_MAP[rd_idx].mask;
      end
   end

   // Shift out on falling edges, release at frame end
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         tx_q <= 8'h00;
         tx_left_q <= 4'h0;
         serial_data_line_out <= 1'b0;
         serial_data_line_oe_n <= 1'b1;
      end else if (sen_n) begin
         tx_left_q <= 4'h0;
         serial_data_line_oe_n <= 1'b1;
      end else if (addr_done && addr_word[RW_BIT]) begin
         tx_q <= rd_value;
         tx_left_q <= 4'(DATA_BITS);
      end else if (sclk_fall && (tx_left_q != 4'h0)) begin
         serial_data_line_out <= tx_q[7];
         serial_data_line_oe_n <= 1'b0;
         tx_q <= {tx_q[6:0], 1'b0};
         tx_left_q <= tx_left_q - 4'h1;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   property p_pdn_code;
      (pin_cfg == CFG_PDN1) |-> (pin_map.fn1 == FN_PDN)
         && (pin_map.fn0 != FN_PDN);
   endproperty
   a_pdn_code: assert property (p_pdn_code)
      else $error("pin one not powerdown for its code");

   property p_pdn_clock;
      !clk_run_s |=> $stable(global_powerdown);
   endproperty
   a_pdn_clock: assert property (p_pdn_clock)
      else $error("powerdown moved without sampling clock");

   property p_default_roles;
      (pin_cfg == CFG_DEFAULT) |-> (pin_map.fn0 == FN_SYNC)
         && (pin_map.fn1 == FN_NONE);
   endproperty
   a_default_roles: assert property (p_default_roles)
      else $error("default pin roles wrong");

   property p_pin_pdn;
      (clk_run_s && pin_level(pin_map, gp_s, FN_PDN))
         |=> global_powerdown;
   endproperty
   a_pin_pdn: assert property (p_pin_pdn)
      else $error("pin powerdown not taken");

   property p_read_blocks;
      rd_flag_q |-> !wr_fire;
   endproperty
   a_read_blocks: assert property (p_read_blocks)
      else $error("write during read frame");

   property p_drive_fall;
      (!serial_data_line_oe_n && !$past(serial_data_line_oe_n)
         && $changed(serial_data_line_out)) |-> $past(sclk_fall);
   endproperty
   a_drive_fall: assert property (p_drive_fall)
      else $error("read data changed off a falling edge");

   property p_unused_zero;
      (addr_done && addr_word[RW_BIT] && (rd_idx >= 0))
         |=> (tx_q & ~REG_MAP[$past(rd_idx)].mask) == 8'h00;
   endproperty
   a_unused_zero: assert property (p_unused_zero)
      else $error("unused bits read nonzero");

   property p_release;
      $rose(sen_n) |=> serial_data_line_oe_n && (bit_cnt_q == 5'h00);
   endproperty
   a_release: assert property (p_release)
      else $error("frame end did not release line");

   property p_wake;
      $fell(global_powerdown) |-> wake_busy ##1 wake_busy;
   endproperty
   a_wake: assert property (p_wake)
      else $error("wake timer not running");

endmodule

`default_nettype wire

// file: test/scp_host_model.sv
// Host controller model driving the serial configuration port
`timescale 1ns/1ps
`default_nettype none

module scp_host_model (
   output logic sel_n,
   output logic sclk,
   output logic sdo,
   input wire logic sdi
);
   // Idle frame select high, shift clock parked low
   initial begin
      sel_n = 1'b1;
      sclk = 1'b0;
      sdo = 1'b0;
   end

   // One whole frame: address word, then data byte, 160 ns bit time
   task automatic xfer(input logic [15:0] a, input logic [7:0] d,
         output logic [7:0] q);
      logic [23:0] f;
      f = {a, d};
      q = 8'h00;
      // Step 1 ns off the clock edge so no change races the sampler
      #1;
      sel_n = 1'b0;
      #80;
      for (int i = 23; i >= 0; i--) begin
         sclk = 1'b0;
         // Released during read data: toggle so no stale level remains
         sdo = (a[15] && i < 8) ? ~sdo : f[i];
         #80;
         sclk = 1'b1;
         q = {q[6:0], sdi};
         #80;
      end
      sclk = 1'b0;
      #80;
      sel_n = 1'b1;
      #79;
   endtask
endmodule

`default_nettype wire

// file: test/test_serial_config_port_regs.sv
// Self-checking bench for the serial configuration port
`timescale 1ns/1ps
`default_nettype none

module test_serial_config_port_regs;
   import scp_pkg::*;
   logic clock, rst, sel_n, sclk, sdo, sdi, dout, doe_n;
   logic g0, g1, scr, ovr, pdn, wb, sp, tp, vr, nco, cr;
   gpin_t gz, go;
   logic [7:0] q, d;
   logic [7:0] mem [NREG];
   logic [4:0] pcode [3] = '{CFG_PDN1, CFG_PDN0_A, CFG_PDN0_B};
   logic [4:0] rcode [10] = '{CFG_DEFAULT, CFG_TSTAMP1, CFG_VREF1,
      CFG_NCO1, CFG_OVR1, CFG_VREF0, CFG_NCO0, CFG_TSTAMP0, CFG_OVR0,
      5'h1F};
   int n_fail, checked, cyc, n;

   // Data line level from whichever end drives it
   assign sdi = doe_n ? sdo : dout;

   scp_host_model scp_host_model_inst (.sel_n(sel_n), .sclk(sclk),
      .sdo(sdo), .sdi(sdi));

   serial_config_port_regs #(.WAKE_CYCLES_P(20))
      serial_config_port_regs_inst (.clock(clock), .rst(rst),
      .serial_frame_select_n(sel_n), .serial_clock(sclk),
      .serial_data_line_in(sdi), .serial_data_line_out(dout),
      .serial_data_line_oe_n(doe_n), .general_pin_zero_in(g0),
      .general_pin_zero_drv(gz), .general_pin_one_in(g1),
      .general_pin_one_drv(go), .sampling_clock_running(scr),
      .overrange_flag(ovr), .global_powerdown(pdn), .wake_busy(wb),
      .sync_reference_pulse(sp), .timestamp_pulse(tp),
      .ext_vref_select(vr), .nco_switch(nco), .config_ready(cr));

   // 100 MHz clock
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // Hang guard
   always @(posedge clock) begin
      cyc++;
      if (cyc == 80000) begin
         n_fail++;
         results();
      end
   end

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [7:0] e, s);
      checked++;
      if (s !== e) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic wt(input int c);
      repeat (c) @(negedge clock);
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] v);
      scp_host_model_inst.xfer({4'h0, a}, v, q);
   endtask

   task automatic rd(input logic [11:0] a);
      scp_host_model_inst.xfer({4'h8, a}, 8'h00, q);
      chk("line release", 8'h01, 8'(doe_n));
   endtask

   // Read-back value of a register after writing v
   function automatic logic [7:0] expv(reg_ent_t e, logic [7:0] v);
      case (e.addr)
         ADDR_CFG_READY: expv = 8'h10;
         ADDR_SOFT_RESET, ADDR_SYNC_CLR, ADDR_SYNC_STATUS: expv = 8'h00;
         default: expv = v & e.mask;
      endcase
   endfunction

   // Pin roles seen with both pins raised:
   // {sync + 2 * timestamp pulses, vref, nco, pin0 oe_n, pin1 oe_n}
   function automatic logic [5:0] roles(logic [4:0] c);
      case (c)
         CFG_TSTAMP1: roles = 6'h33;
         CFG_VREF1: roles = 6'h1B;
         CFG_NCO1: roles = 6'h17;
         CFG_OVR1: roles = 6'h12;
         CFG_VREF0: roles = 6'h0B;
         CFG_NCO0: roles = 6'h07;
         CFG_TSTAMP0: roles = 6'h23;
         CFG_OVR0: roles = 6'h11;
         default: roles = 6'h13;
      endcase
   endfunction

   task automatic results;
      if (n_fail == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      rst = 1'b1;
      g0 = 1'b0;
      g1 = 1'b0;
      scr = 1'b1;
      ovr = 1'b0;
      n_fail = 0;
      checked = 0;
      cyc = 0;
      void'($urandom(62));
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      wt(4);
      // Default pin roles with no serial access
      chk("ready", 8'h01, 8'(cr));
      @(posedge clock) {g0, g1} <= 2'b11;
      n = 0;
      repeat (8) begin
         @(negedge clock);
         n += sp + 2 * tp;
      end
      chk("pin pulses", 8'h01, 8'(n));
      chk("pin roles", 8'h00, 8'({vr, nco, pdn}));
      @(posedge clock) {g0, g1} <= 2'b00;
      rd(ADDR_SYNC_STATUS);
      chk("sync det", 8'h40, q);
      wr(ADDR_SYNC_CLR, 8'h40);
      rd(ADDR_SYNC_STATUS);
      chk("sync clr", 8'h00, q);
      // Random data through every mapped register
      foreach (mem[i]) begin
         d = 8'($urandom);
         if (REG_MAP[i].addr == ADDR_SOFT_RESET)
            d[0] = 1'b0;
         mem[i] = d;
         wr(REG_MAP[i].addr, d);
      end
      foreach (mem[i]) begin
         rd(REG_MAP[i].addr);
         chk("reg", expv(REG_MAP[i], mem[i]), q);
      end
      // Refused writes, unmapped place, soft reset
      scp_host_model_inst.xfer({4'h8, 12'h14B}, 8'h5A, q);
      scp_host_model_inst.xfer({4'h1, 12'h14B}, 8'h5A, q);
      rd(12'h14B);
      chk("refused", mem[26], q);
      rd(12'h0FF);
      chk("unmapped", 8'h00, q);
      wr(ADDR_SOFT_RESET, 8'h01);
      rd(12'h14B);
      chk("soft reset", 8'h00, q);
      // Every non-powerdown pin role code, plus one random unlisted code
      rcode[9] = 5'h10 | 5'($urandom);
      foreach (rcode[k]) begin
         wr(ADDR_PIN_CFG, {3'b000, rcode[k]});
         @(posedge clock) {g0, g1} <= 2'b11;
         n = 0;
         repeat (8) begin
            @(negedge clock);
            n += sp + 2 * tp;
         end
         d = 8'({n[1:0], vr, nco, gz.oe_n, go.oe_n});
         chk("roles", 8'(roles(rcode[k])), d);
         @(posedge clock) {g0, g1} <= 2'b00;
      end
      // Powerdown by pin, gated by the sampling clock
      foreach (pcode[k]) begin
         wr(ADDR_PIN_CFG, {3'b000, pcode[k]});
         @(posedge clock) scr <= 1'b0;
         if (k == 0)
            g1 <= 1'b1;
         else
            g0 <= 1'b1;
         wt(8);
         chk("pdn no clock", 8'h00, 8'(pdn));
         @(posedge clock) scr <= 1'b1;
         wt(8);
         chk("pdn", 8'h01, 8'(pdn));
         @(posedge clock) {g0, g1} <= 2'b00;
         wt(8);
         chk("waking", 8'h01, 8'({pdn, wb}));
         wt(30);
         chk("awake", 8'h00, 8'(wb));
      end
      // Pin one as overrange output under code 01011
      @(posedge clock) ovr <= 1'($urandom);
      wt(4);
      chk("ovr pin", 8'({ovr, 1'b0}), 8'(go));
      chk("pin zero idle", 8'({ovr, 1'b1}), 8'(gz));
      @(posedge clock) ovr <= ~ovr;
      wt(4);
      chk("ovr pin flip", 8'({ovr, 1'b0}), 8'(go));
      wr(ADDR_PIN_CFG, {3'b000, CFG_VREF0});
      @(posedge clock) g0 <= 1'b1;
      wt(8);
      chk("vref", 8'h01, 8'(vr));
      results();
   end
endmodule

`default_nettype wire
